// ---- rtl/bank_legal.sv ----
`timescale 1ns/1ps
`default_nettype none
module bank_legal (
  input wire logic clk,
  input wire logic rst_b,
  input wire bank_legal_pkg::cmd_pins_t pins,
  input wire bank_legal_pkg::timing_cfg_t cfg,
  output logic [4*bank_legal_pkg::NUM_BANKS-1:0] bank_state_flat,
  output logic violation,
  output logic [bank_legal_pkg::BANK_W-1:0] violation_bank
);
  import bank_legal_pkg::*;

  bank_state_t state_reg [NUM_BANKS];
  bank_state_t state_next [NUM_BANKS];
  logic [CNT_W-1:0] cnt_reg [NUM_BANKS];
  logic [CNT_W-1:0] cnt_next [NUM_BANKS];
  logic [NUM_BANKS-1:0] bad_bank;
  logic viol_next;
  logic [BANK_W-1:0] vbank_next;
  logic all_idle;

  // command decode, sampled at the rising edge
  function automatic cmd_t decode(input cmd_pins_t p);
    if (p.cs_b) return CMD_DESEL;
    case ({p.ras_b, p.cas_b, p.we_b})
      3'h7: return CMD_NOP;
      3'h5: return CMD_READ;
      3'h4: return CMD_WRITE;
      3'h3: return CMD_ACT;
      3'h2: return CMD_PRE;
      3'h1: return CMD_REF;
      default: return CMD_MRS;
    endcase
  endfunction

  wire cmd_t cmd = decode(pins);
  wire logic is_wait = (cmd == CMD_DESEL) || (cmd == CMD_NOP);
  wire logic is_all = (cmd == CMD_REF) || (cmd == CMD_MRS) || (cmd == CMD_PRE && pins.ap);

  // per bank next state and legality
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      logic hit;
      logic done;
      hit = (pins.bank == BANK_W'(b)) || is_all;
      done = (cnt_reg[b] <= CNT_ONE);
      state_next[b] = state_reg[b];
      cnt_next[b] = (cnt_reg[b] == CNT_ZERO) ? CNT_ZERO : cnt_reg[b] - CNT_ONE;
      bad_bank[b] = 1'b0;
      case (state_reg[b])
        ST_IDLE: begin
          if (hit && cmd == CMD_ACT) begin
            state_next[b] = ST_ACTIVATING;
            cnt_next[b] = cfg.trcd;
          end else if (cmd == CMD_REF && all_idle) begin
            state_next[b] = ST_REFRESHING;
            cnt_next[b] = cfg.trfc;
          end else if (hit && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
            bad_bank[b] = 1'b1;
          end
        end
        ST_ACTIVATING: begin
          if (hit && !is_wait) begin
            // early column command only when AL hides tRCD
            if ((cmd == CMD_READ || cmd == CMD_WRITE) && cfg.al_covers_trcd) begin
              state_next[b] = ST_ACTIVE;
            end else begin
              bad_bank[b] = 1'b1;
            end
          end else if (done) begin
            state_next[b] = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (hit && cmd == CMD_WRITE) begin
            if (pins.ap && !cfg.wra_ok) bad_bank[b] = 1'b1;
            state_next[b] = pins.ap ? ST_WRITE_AP : ST_WR_RECOVER;
            cnt_next[b] = pins.ap ? cfg.burst : cfg.twr;
          end else if (hit && cmd == CMD_READ && pins.ap) begin
            state_next[b] = ST_READ_AP;
            cnt_next[b] = cfg.burst;
          end else if (hit && cmd == CMD_PRE) begin
            state_next[b] = ST_PRECHARGING;
            cnt_next[b] = cfg.trp;
          end else if (hit && (cmd == CMD_ACT || cmd == CMD_REF || cmd == CMD_MRS)) begin
            bad_bank[b] = 1'b1;
          end
        end
        ST_READ_AP, ST_WRITE_AP: begin
          // any addressed command breaks the auto-precharge burst
          if (hit && !is_wait) begin
            bad_bank[b] = 1'b1;
          end else if (done) begin
            state_next[b] = (state_reg[b] == ST_READ_AP) ? ST_PRECHARGING : ST_WR_RECOVER_AP;
            cnt_next[b] = (state_reg[b] == ST_READ_AP) ? cfg.trp : cfg.twr;
          end
        end
        ST_PRECHARGING: begin
          if (hit && !is_wait && cmd != CMD_PRE) begin
            bad_bank[b] = 1'b1;
          end else if (done) begin
            state_next[b] = ST_IDLE;
          end
        end
        ST_WR_RECOVER: begin
          if (hit && cmd == CMD_WRITE) begin
            cnt_next[b] = cfg.twr; // another write restarts recovery
          end else if (hit && !is_wait) begin
            bad_bank[b] = 1'b1;
          end else if (done) begin
            state_next[b] = ST_ACTIVE;
          end
        end
        ST_WR_RECOVER_AP: begin
          if (hit && !is_wait) begin
            bad_bank[b] = 1'b1;
          end else if (done) begin
            state_next[b] = ST_PRECHARGING;
            cnt_next[b] = cfg.trp;
          end
        end
        ST_REFRESHING: begin
          // every bank refreshes together, so the addressed bank is the offender
          if (hit && !is_wait) begin
            bad_bank[b] = 1'b1;
          end else if (done) begin
            state_next[b] = ST_IDLE;
          end
        end
        default: begin
          state_next[b] = ST_IDLE;
          cnt_next[b] = CNT_ZERO;
        end
      endcase
      // refresh and mode set need every bank idle
      if ((cmd == CMD_REF || cmd == CMD_MRS) && state_reg[b] != ST_IDLE) bad_bank[b] = 1'b1;
    end
  end

  // refresh starts only from all-idle; an illegal refresh must not move any bank
  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (state_reg[b] != ST_IDLE) all_idle = 1'b0;
    end
  end

  // lowest offending bank is reported
  always_comb begin
    vbank_next = '0;
    for (int b = NUM_BANKS - 1; b >= 0; b--) begin
      if (bad_bank[b]) vbank_next = BANK_W'(b);
    end
  end
  assign viol_next = |bad_bank;

  // per-bank state and counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        state_reg[b] <= ST_IDLE;
        cnt_reg[b] <= CNT_ZERO;
      end
      violation <= 1'b0;
      violation_bank <= '0;
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        state_reg[b] <= state_next[b];
        cnt_reg[b] <= cnt_next[b];
      end
      violation <= viol_next;
      violation_bank <= vbank_next;
    end
  end

  // state codes packed four bits per bank
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) bank_state_flat[4*b +: 4] = state_reg[b];
  end

  sequence s_refresh_start;
    cmd == CMD_REF && !viol_next;
  endsequence

  sequence s_slow_wra;
    cmd == CMD_WRITE && pins.ap && !cfg.wra_ok && state_reg[pins.bank] == ST_ACTIVE;
  endsequence

  a_precharge_to_idle: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg[0] == ST_PRECHARGING && cnt_reg[0] == CNT_ONE && is_wait)
    |=> state_reg[0] == ST_IDLE) else $error("precharge did not end in idle");
  a_activate_waits: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg[0] == ST_ACTIVATING && cnt_reg[0] > CNT_ONE && is_wait)
    |=> state_reg[0] == ST_ACTIVATING) else $error("bank active before tRCD");
  a_refresh_entry: assert property (@(posedge clk) disable iff (!rst_b)
    s_refresh_start |=> state_reg[0] == ST_REFRESHING && cnt_reg[0] == cfg.trfc)
    else $error("refresh did not load tRFC");
  a_refresh_rw_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg[1] == ST_REFRESHING && (cmd == CMD_READ || cmd == CMD_WRITE))
    |=> violation) else $error("read during refresh not flagged");
  a_read_ap_burst: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg[0] == ST_READ_AP && cnt_reg[0] > CNT_ONE && is_wait)
    |=> state_reg[0] == ST_READ_AP) else $error("read burst cut short");
  a_write_ap_flow: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg[0] == ST_WRITE_AP && cnt_reg[0] == CNT_ONE && is_wait)
    |=> state_reg[0] == ST_WR_RECOVER_AP) else $error("write burst end wrong");
  a_recover_active: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg[0] == ST_WR_RECOVER && cnt_reg[0] == CNT_ONE && is_wait)
    |=> state_reg[0] == ST_ACTIVE) else $error("recovery did not return active");
  a_recover_ap_pre: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg[0] == ST_WR_RECOVER_AP && cnt_reg[0] == CNT_ONE && is_wait)
    |=> state_reg[0] == ST_PRECHARGING && cnt_reg[0] == cfg.trp)
    else $error("auto precharge after recovery missing");
  a_illegal_flag: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg[0] == ST_READ_AP && pins.bank == 2'h0 && (cmd == CMD_ACT || cmd == CMD_PRE))
    |=> violation && violation_bank == 2'h0) else $error("illegal command not flagged");

  // flag is a pulse: waits never raise it, slow-clock auto precharge writes to an active bank always do
  a_wait_no_flag: assert property (@(posedge clk) disable iff (!rst_b)
    is_wait |=> !violation) else $error("wait command raised the flag");
  a_slow_wra_flag: assert property (@(posedge clk) disable iff (!rst_b)
    s_slow_wra |=> violation) else $error("slow-clock auto precharge write not flagged");
endmodule
`default_nettype wire

// ---- rtl/bank_legal_pkg.sv ----
// Notes on behaviour
// - read with auto precharge: deselect or nop lets the burst finish.
// - write with auto precharge: deselect or nop lets the burst finish.
// - precharging bank goes idle after tRP; extra precharge acts as nop.
// - activating bank becomes active after tRCD elapses, or at once on a read or write when AL covers tRCD.
// - write recovery returns bank to active after tWR.
// - write recovery after auto-precharge write moves on only after tWR.
// - after refresh, idle only once tRFC has elapsed.
// - illegal commands are flagged as violations.
package bank_legal_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int CNT_W = 8;
  localparam int CLK_PS = 10000;
  localparam int TRP_PS = 15000;
  localparam int TRCD_PS = 15000;
  localparam int TWR_PS = 15000;
  localparam int TRFC_PS = 75000;
  localparam int TBURST_CYC = 4;
  // least times round up
  localparam logic [CNT_W-1:0] TRP_CYC = CNT_W'((TRP_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] TRCD_CYC = CNT_W'((TRCD_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] TWR_CYC = CNT_W'((TWR_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] TRFC_CYC = CNT_W'((TRFC_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(TBURST_CYC);
  localparam int TCK_MIN_WRA_PS = 1875;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_ACTIVATING = 4'b0001, ST_ACTIVE = 4'b0010,
    ST_READ_AP = 4'b0011, ST_WRITE_AP = 4'b0100, ST_PRECHARGING = 4'b0101,
    ST_WR_RECOVER = 4'b0110, ST_WR_RECOVER_AP = 4'b0111, ST_REFRESHING = 4'b1000
  } bank_state_t;

  typedef enum logic [3:0] {
    CMD_DESEL = 4'b0000, CMD_NOP = 4'b0001, CMD_READ = 4'b0010, CMD_WRITE = 4'b0011,
    CMD_ACT = 4'b0100, CMD_PRE = 4'b0101, CMD_REF = 4'b0110, CMD_MRS = 4'b0111
  } cmd_t;

  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [BANK_W-1:0] bank;
    logic ap;
  } cmd_pins_t;

  typedef struct packed {
    logic [CNT_W-1:0] trp;
    logic [CNT_W-1:0] trcd;
    logic [CNT_W-1:0] twr;
    logic [CNT_W-1:0] trfc;
    logic [CNT_W-1:0] burst;
    logic al_covers_trcd;
    logic wra_ok;
  } timing_cfg_t;
endpackage

// ---- test/bank_legal_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bank_legal_tb;
  import bank_legal_pkg::*;
  // {cs_b, ras_b, cas_b, we_b}
  localparam logic [3:0] DES = 4'h8;
  localparam logic [3:0] RD = 4'h5;
  localparam logic [3:0] WR = 4'h4;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] REF = 4'h1;
  // distinct counts, except TRP and TWR which are both 5, so an off-by-one in one timer cannot hide behind another
  localparam int TRP = 5;
  localparam int TRCD = 3;
  localparam int TWR = 5;
  localparam int TRFC = 6;
  localparam int BURST = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  timing_cfg_t cfg;
  cmd_pins_t pins;
  logic [4*NUM_BANKS-1:0] bank_state_flat;
  logic violation;
  logic [BANK_W-1:0] violation_bank;
  int failures = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  ctrl_model ctrl_u (.clk(clk), .pins(pins));
  bank_legal dut_u (.clk(clk), .rst_b(rst_b), .pins(pins), .cfg(cfg),
    .bank_state_flat(bank_state_flat), .violation(violation),
    .violation_bank(violation_bank));
  task automatic chk(input int b, input logic [3:0] st, input logic v);
    logic [3:0] got;
    got = bank_state_flat[4*b +: 4];
    comparisons++;
    if (got !== st || violation !== v || (v && violation_bank !== 2'(b))) begin
      failures++;
      $display("[ERR] t=%0t exp %h got %h", $time, {st, v, 2'(b)},
               {got, violation, violation_bank});
    end
  endtask
  // command then one deselect; judged after the edge that took it
  task automatic step(input logic [3:0] c, input int b, input logic a,
                      input logic [3:0] st, input logic v);
    ctrl_u.issue(c, 2'(b), a);
    ctrl_u.issue(DES, 2'h0, 1'b0);
    #1 chk(b, st, v);
  endtask
  // k idle edges, the last one must show the next state
  task automatic run(input int b, input int k, input logic [3:0] cur, input logic [3:0] nxt);
    for (int i = 1; i <= k; i++) begin
      ctrl_u.issue(DES, 2'h0, 1'b0);
      #1 chk(b, (i == k) ? nxt : cur, 1'b0);
    end
  endtask
  task automatic t_act();
    step(ACT, 0, 1'b0, 4'h1, 1'b0);
    step(RD, 0, 1'b0, 4'h1, 1'b1);
    run(0, TRCD - 2, 4'h1, 4'h2);
    $display("test act done");
  endtask
  task automatic t_rdap();
    step(RD, 0, 1'b1, 4'h3, 1'b0);
    step(PRE, 0, 1'b0, 4'h3, 1'b1);
    run(0, BURST - 2, 4'h3, 4'h5);
    step(PRE, 0, 1'b0, 4'h5, 1'b0);
    step(ACT, 0, 1'b0, 4'h5, 1'b1);
    run(0, TRP - 4, 4'h5, 4'h0);
    $display("test rdap done");
  endtask
  task automatic t_wr();
    step(ACT, 1, 1'b0, 4'h1, 1'b0);
    run(1, TRCD, 4'h1, 4'h2);
    step(WR, 1, 1'b0, 4'h6, 1'b0);
    step(ACT, 1, 1'b0, 4'h6, 1'b1);
    run(1, TWR - 2, 4'h6, 4'h2);
    $display("test wr done");
  endtask
  task automatic t_wrap();
    step(WR, 1, 1'b1, 4'h4, 1'b0);
    run(1, BURST, 4'h4, 4'h7);
    step(PRE, 1, 1'b0, 4'h7, 1'b1);
    run(1, TWR - 2, 4'h7, 4'h5);
    run(1, TRP, 4'h5, 4'h0);
    $display("test wrap done");
  endtask
  task automatic t_ref();
    step(REF, 2, 1'b0, 4'h8, 1'b0);
    step(RD, 2, 1'b0, 4'h8, 1'b1);
    run(2, TRFC - 2, 4'h8, 4'h0);
    $display("test ref done");
  endtask
  // slow clock: write with auto precharge is flagged yet still runs; other banks stay free
  task automatic t_wra_slow();
    step(ACT, 3, 1'b0, 4'h1, 1'b0);
    run(3, TRCD, 4'h1, 4'h2);
    @(posedge clk);
    cfg.wra_ok <= 1'b0;
    step(WR, 3, 1'b1, 4'h4, 1'b1);
    step(ACT, 0, 1'b0, 4'h1, 1'b0);
    chk(3, 4'h4, 1'b0);
    $display("test wra slow done");
  endtask
  // reset in mid-run: busy banks fall back to idle, first command taken after release
  task automatic t_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1 chk(0, 4'h0, 1'b0);
    chk(3, 4'h0, 1'b0);
    @(posedge clk);
    rst_b <= 1'b1;
    step(ACT, 2, 1'b0, 4'h1, 1'b0);
    $display("test reset done");
  endtask
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    cfg = '{8'(TRP), 8'(TRCD), 8'(TWR), 8'(TRFC), 8'(BURST), 1'b0, 1'b1};
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_act();
    t_rdap();
    t_wr();
    t_wrap();
    t_ref();
    t_wra_slow();
    t_reset();
    final_report();
  end
  // the whole run is well under a hundred cycles
  initial begin
    #3000;
    failures++;
    final_report();
  end
endmodule
`default_nettype wire

// ---- test/ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  input wire logic clk,
  output var bank_legal_pkg::cmd_pins_t pins
);
  import bank_legal_pkg::*;
  initial pins = '{1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0};
  // one command per edge; deselect flips the idle lines so nothing leans on them
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic a);
    @(posedge clk);
    if (c[3]) begin
      pins <= '{1'b1, ~pins.ras_b, ~pins.cas_b, ~pins.we_b, ~pins.bank, ~pins.ap};
    end else begin
      pins <= '{1'b0, c[2], c[1], c[0], b, a};
    end
  endtask
endmodule
`default_nettype wire
